// ===== inc/dbg_cmd_pkg.sv
// package: constants and carriers of the debug serial command engine
// Notes on behaviour
// - addresses always two extension words, 32 bits
// - word and longword addresses forced aligned
// - immediate data: one word, two for longword
// - multi-word values travel high word first
// - every exchange is one 17-bit transfer
// - command word answered by previous result/status
// - next transfer not-ready, or illegal-command response
// - low address word answered not-ready, then read
// - transfers during memory access answer not-ready
// - results follow in the next one or two transfers, two for longword and register
// - byte read result sits in low eight bits
// - bus error returns status set, data 0x0001
// - status clear when done, set otherwise
// - unassigned encodings drop the dump chain, answer illegal
// - register read returns 32 bits, needs halt
// - register write: all 32 bits, answers 0xffff
// - memory space from attribute type/modifier fields
// - memory read words 0x1900, 0x1940, 0x1980
// - write byte data low-justified, answers 0xffff
// - dump legal only after nop, read, dump
// - temporary address advances by operand size
// - dump size re-examined on every dump
// - op 15:10, direction bit 8, size 7:6
// - dump words 0x1d00, 0x1d40, 0x1d80
// - nop word 0x0000 does nothing
package dbg_cmd_pkg;
  // ------------------------------------------------------------
  // serial frame and command fields
  // ------------------------------------------------------------
  localparam logic [4:0] FRAME_LAST = 5'h10;
  localparam int SIZE_LSB = 6;
  localparam int DIR_BIT = 8;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;
  localparam logic [15:0] CMD_NOP = 16'h0000;
  localparam logic [7:0] CMD_READ = 8'h19;
  localparam logic [7:0] CMD_WRITE = 8'h18;
  localparam logic [7:0] CMD_DUMP = 8'h1d;
  localparam logic [11:0] CMD_RREG = 12'h218;
  localparam logic [11:0] CMD_WREG = 12'h208;
  // ------------------------------------------------------------
  // register map, wishbone byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ATTR_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int TT_LSB = 0;
  localparam int TM_LSB = 2;
  localparam logic [4:0] ATTR_RST = 5'h00;
  localparam int STAT_CHAIN_BIT = 9;
  localparam int STAT_BUSY_BIT = 10;
  localparam int STAT_HALT_BIT = 11;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic s;
    logic [15:0] data;
  } resp_s;
  localparam resp_s RSP_NOT_READY = '{s: 1'b1, data: 16'h0000};
  localparam resp_s RSP_ILLEGAL = '{s: 1'b1, data: 16'hffff};
  localparam resp_s RSP_BUSERR = '{s: 1'b1, data: 16'h0001};
  localparam resp_s RSP_DONE = '{s: 1'b0, data: 16'hffff};
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [1:0] tt;
    logic [2:0] tm;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [3:0] sel;
    logic [31:0] wdata;
  } reg_req_s;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR_HI = 9'h002,
    ST_ADDR_LO = 9'h004,
    ST_DATA_HI = 9'h008,
    ST_DATA_LO = 9'h010,
    ST_WAIT = 9'h020,
    ST_MEM = 9'h040,
    ST_REG = 9'h080,
    ST_RES_LO = 9'h100
  } state_e;
  typedef struct packed {
    state_e st;
    resp_s rsp;
    logic [15:0] cmd;
    logic [31:0] addr;
    logic [31:0] tmp_addr;
    logic [31:0] data;
    logic [15:0] res_lo;
    logic chain;
    mem_req_s mem;
    reg_req_s rg;
    logic [4:0] attr;
    logic wb_ack;
    logic [31:0] wb_dat;
  } eng_s;
  localparam eng_s ENG_RST = '{st: ST_IDLE, rsp: RSP_DONE,
                               attr: ATTR_RST, default: '0};
  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dat_s1;
    logic dat_s2;
    logic [4:0] cnt;
    logic [16:0] rx;
    logic [16:0] tx;
    logic done;
  } link_s;
  localparam link_s LINK_RST = '0;
endpackage

// ===== design/serial_shifter.sv
// serial shifter: 17-bit exchange sampled on the processor clock
`timescale 1ns/1ps
module serial_shifter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dsclk_i,
  input wire logic dsi_i,
  input wire dbg_cmd_pkg::resp_s rsp_i,
  output logic dso_o,
  output logic frame_valid_o,
  output dbg_cmd_pkg::resp_s frame_o
);
  dbg_cmd_pkg::link_s lk_reg;
  dbg_cmd_pkg::link_s lk_next;

  // ------------------------------------------------------------
  // shift logic
  // ------------------------------------------------------------
  always_comb begin
    lk_next = lk_reg;
    lk_next.clk_s1 = dsclk_i;
    lk_next.clk_s2 = lk_reg.clk_s1;
    lk_next.clk_s3 = lk_reg.clk_s2;
    lk_next.dat_s1 = dsi_i;
    lk_next.dat_s2 = lk_reg.dat_s1;
    lk_next.done = 1'b0;
    // the answer tracks the engine until the first edge of a frame
    if (lk_reg.cnt == 5'h00) begin
      lk_next.tx = rsp_i;
    end
    if (lk_reg.clk_s2 && !lk_reg.clk_s3) begin
      lk_next.rx = {lk_reg.rx[15:0], lk_reg.dat_s2};
      lk_next.tx = {lk_reg.tx[15:0], 1'b0};
      if (lk_reg.cnt == dbg_cmd_pkg::FRAME_LAST) begin
        lk_next.cnt = 5'h00;
        lk_next.done = 1'b1;
      end else begin
        lk_next.cnt = lk_reg.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk_reg <= dbg_cmd_pkg::LINK_RST;
    end else begin
      lk_reg <= lk_next;
    end
  end

  assign dso_o = lk_reg.tx[16];
  assign frame_valid_o = lk_reg.done;
  assign frame_o = dbg_cmd_pkg::resp_s'(lk_reg.rx);
endmodule

// ===== design/debug_serial_command_engine.sv
// debug command engine: decode, memory and register access, wishbone
`timescale 1ns/1ps
module debug_serial_command_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dsclk_i,
  input wire logic dsi_i,
  output logic dso_o,
  input wire logic cpu_halted_i,
  output dbg_cmd_pkg::mem_req_s mem_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  output dbg_cmd_pkg::reg_req_s reg_o,
  input wire logic [31:0] reg_rdata_i,
  input wire logic reg_ack_i
);
  dbg_cmd_pkg::eng_s st_reg;
  dbg_cmd_pkg::eng_s st_next;
  logic fv;
  dbg_cmd_pkg::resp_s frm;
  logic [15:0] w;
  logic [1:0] wsz;
  logic mem_ok;
  logic is_nop;
  logic is_rd;
  logic is_wr;
  logic is_dmp;
  logic is_rreg;
  logic is_wreg;
  logic illegal;
  logic cmd_long;

  // ------------------------------------------------------------
  // serial link
  // ------------------------------------------------------------
  serial_shifter u_link (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dsclk_i(dsclk_i),
    .dsi_i(dsi_i),
    .rsp_i(st_reg.rsp),
    .dso_o(dso_o),
    .frame_valid_o(fv),
    .frame_o(frm)
  );

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  assign w = frm.data;
  assign wsz = w[dbg_cmd_pkg::SIZE_LSB +: 2];
  assign mem_ok = (w[5:0] == 6'h00) && (wsz != dbg_cmd_pkg::SZ_RSVD);
  assign is_nop = (w == dbg_cmd_pkg::CMD_NOP);
  assign is_rd = (w[15:8] == dbg_cmd_pkg::CMD_READ) && mem_ok;
  assign is_wr = (w[15:8] == dbg_cmd_pkg::CMD_WRITE) && mem_ok;
  assign is_dmp = (w[15:8] == dbg_cmd_pkg::CMD_DUMP) && mem_ok;
  assign is_rreg = (w[15:4] == dbg_cmd_pkg::CMD_RREG);
  assign is_wreg = (w[15:4] == dbg_cmd_pkg::CMD_WREG);
  // a dump with no preceding read is as illegal as an unknown word
  assign illegal = !(is_nop || is_rd || is_wr || is_rreg || is_wreg ||
                     (is_dmp && st_reg.chain));
  assign cmd_long = (st_reg.cmd[dbg_cmd_pkg::SIZE_LSB +: 2] ==
                     dbg_cmd_pkg::SZ_LONG);

  // force low address bits to zero for the operand size
  function automatic logic [31:0] align(input logic [31:0] a,
                                        input logic [1:0] sz);
    logic [31:0] r;
    r = a;
    if (sz == dbg_cmd_pkg::SZ_WORD) begin
      r[0] = 1'b0;
    end else if (sz == dbg_cmd_pkg::SZ_LONG) begin
      r[1:0] = 2'h0;
    end
    return r;
  endfunction

  function automatic logic [31:0] step(input logic [1:0] sz);
    logic [31:0] r;
    r = 32'h0000_0001;
    if (sz == dbg_cmd_pkg::SZ_WORD) begin
      r = 32'h0000_0002;
    end else if (sz == dbg_cmd_pkg::SZ_LONG) begin
      r = 32'h0000_0004;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // engine and register file
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // wishbone: every access acked one cycle after the strobe
    st_next.wb_ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !st_reg.wb_ack) begin
      st_next.wb_ack = 1'b1;
      st_next.wb_dat = 32'h0000_0000;
      if (wb_adr_i == dbg_cmd_pkg::ATTR_OFS) begin
        st_next.wb_dat[4:0] = st_reg.attr;
        if (wb_we_i && wb_sel_i[0]) begin
          st_next.attr = wb_dat_i[4:0];
        end
      end else if (wb_adr_i == dbg_cmd_pkg::STAT_OFS) begin
        st_next.wb_dat[8:0] = st_reg.st;
        st_next.wb_dat[dbg_cmd_pkg::STAT_CHAIN_BIT] = st_reg.chain;
        st_next.wb_dat[dbg_cmd_pkg::STAT_BUSY_BIT] =
          st_reg.mem.req || st_reg.rg.req;
        st_next.wb_dat[dbg_cmd_pkg::STAT_HALT_BIT] = cpu_halted_i;
      end
    end
    unique case (st_reg.st)
      dbg_cmd_pkg::ST_IDLE: begin
        if (fv) begin
          st_next.cmd = w;
          st_next.rsp = dbg_cmd_pkg::RSP_NOT_READY;
          if (illegal) begin
            st_next.rsp = dbg_cmd_pkg::RSP_ILLEGAL;
            st_next.chain = 1'b0;
          end else if (is_nop) begin
            // padding keeps the dump address intact
            st_next.rsp = dbg_cmd_pkg::RSP_DONE;
          end else if (is_dmp) begin
            st_next.addr = st_reg.tmp_addr;
            st_next.st = dbg_cmd_pkg::ST_WAIT;
          end else if (is_rd || is_wr) begin
            st_next.chain = 1'b0;
            st_next.st = dbg_cmd_pkg::ST_ADDR_HI;
          end else if (is_rreg) begin
            st_next.chain = 1'b0;
            st_next.st = dbg_cmd_pkg::ST_WAIT;
          end else begin
            st_next.chain = 1'b0;
            st_next.st = dbg_cmd_pkg::ST_DATA_HI;
          end
        end
      end
      dbg_cmd_pkg::ST_ADDR_HI: begin
        if (fv) begin
          st_next.addr[31:16] = w;
          st_next.st = dbg_cmd_pkg::ST_ADDR_LO;
        end
      end
      dbg_cmd_pkg::ST_ADDR_LO: begin
        if (fv) begin
          st_next.addr[15:0] = w;
          if (st_reg.cmd[dbg_cmd_pkg::DIR_BIT]) begin
            st_next.mem.req = 1'b1;
            st_next.st = dbg_cmd_pkg::ST_MEM;
          end else if (cmd_long) begin
            st_next.st = dbg_cmd_pkg::ST_DATA_HI;
          end else begin
            st_next.st = dbg_cmd_pkg::ST_DATA_LO;
          end
        end
      end
      dbg_cmd_pkg::ST_DATA_HI: begin
        if (fv) begin
          st_next.data[31:16] = w;
          st_next.st = dbg_cmd_pkg::ST_DATA_LO;
        end
      end
      dbg_cmd_pkg::ST_DATA_LO: begin
        if (fv) begin
          // byte data arrives low-justified and is passed as is
          st_next.data[15:0] = w;
          if (st_reg.cmd[15:4] == dbg_cmd_pkg::CMD_WREG) begin
            st_next.st = dbg_cmd_pkg::ST_REG;
            st_next.rg.req = cpu_halted_i;
            if (!cpu_halted_i) begin
              st_next.rsp = dbg_cmd_pkg::RSP_BUSERR;
              st_next.st = dbg_cmd_pkg::ST_IDLE;
            end
          end else begin
            st_next.mem.req = 1'b1;
            st_next.st = dbg_cmd_pkg::ST_MEM;
          end
        end
      end
      dbg_cmd_pkg::ST_WAIT: begin
        // one not-ready transfer separates command and access
        if (fv) begin
          if (st_reg.cmd[15:4] == dbg_cmd_pkg::CMD_RREG) begin
            st_next.st = dbg_cmd_pkg::ST_REG;
            st_next.rg.req = cpu_halted_i;
            if (!cpu_halted_i) begin
              st_next.rsp = dbg_cmd_pkg::RSP_BUSERR;
              st_next.st = dbg_cmd_pkg::ST_IDLE;
            end
          end else begin
            st_next.mem.req = 1'b1;
            st_next.st = dbg_cmd_pkg::ST_MEM;
          end
        end
      end
      dbg_cmd_pkg::ST_MEM: begin
        // frames arriving now were answered not-ready and are dropped
        if (mem_err_i) begin
          st_next.mem.req = 1'b0;
          st_next.chain = 1'b0;
          st_next.rsp = dbg_cmd_pkg::RSP_BUSERR;
          st_next.st = dbg_cmd_pkg::ST_IDLE;
        end else if (mem_ack_i) begin
          st_next.mem.req = 1'b0;
          st_next.st = dbg_cmd_pkg::ST_IDLE;
          if (st_reg.mem.we) begin
            st_next.rsp = dbg_cmd_pkg::RSP_DONE;
          end else begin
            st_next.chain = 1'b1;
            st_next.tmp_addr = st_reg.mem.addr +
                               step(st_reg.mem.size);
            // a byte lands in the low eight bits
            st_next.rsp = '{s: 1'b0, data: mem_rdata_i[15:0]};
            if (st_reg.mem.size == dbg_cmd_pkg::SZ_LONG) begin
              st_next.rsp = '{s: 1'b0, data: mem_rdata_i[31:16]};
              st_next.res_lo = mem_rdata_i[15:0];
              st_next.st = dbg_cmd_pkg::ST_RES_LO;
            end
          end
        end
      end
      dbg_cmd_pkg::ST_REG: begin
        if (reg_ack_i) begin
          st_next.rg.req = 1'b0;
          st_next.st = dbg_cmd_pkg::ST_IDLE;
          st_next.rsp = dbg_cmd_pkg::RSP_DONE;
          if (!st_reg.rg.we) begin
            st_next.rsp = '{s: 1'b0, data: reg_rdata_i[31:16]};
            st_next.res_lo = reg_rdata_i[15:0];
            st_next.st = dbg_cmd_pkg::ST_RES_LO;
          end
        end
      end
      dbg_cmd_pkg::ST_RES_LO: begin
        if (fv) begin
          st_next.rsp = '{s: 1'b0, data: st_reg.res_lo};
          st_next.st = dbg_cmd_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next.st = dbg_cmd_pkg::ST_IDLE;
      end
    endcase
    // request fields follow the command while no access is running
    if (!st_reg.mem.req) begin
      st_next.mem.we = !st_reg.cmd[dbg_cmd_pkg::DIR_BIT];
      st_next.mem.size = st_reg.cmd[dbg_cmd_pkg::SIZE_LSB +: 2];
      st_next.mem.addr = align(st_next.addr, st_next.mem.size);
      st_next.mem.wdata = st_next.data;
      st_next.mem.tt = st_reg.attr[dbg_cmd_pkg::TT_LSB +: 2];
      st_next.mem.tm = st_reg.attr[dbg_cmd_pkg::TM_LSB +: 3];
    end
    if (!st_reg.rg.req) begin
      st_next.rg.we = !st_reg.cmd[dbg_cmd_pkg::DIR_BIT];
      st_next.rg.sel = st_reg.cmd[3:0];
      st_next.rg.wdata = st_next.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= dbg_cmd_pkg::ENG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.wb_ack;
  assign wb_dat_o = st_reg.wb_dat;
  assign mem_o = st_reg.mem;
  assign reg_o = st_reg.rg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic idle_frame;
  assign idle_frame = fv && (st_reg.st == dbg_cmd_pkg::ST_IDLE);

  sequence s_long_read_done;
    st_reg.mem.req && mem_ack_i && !mem_err_i && !st_reg.mem.we &&
    (st_reg.mem.size == dbg_cmd_pkg::SZ_LONG);
  endsequence

  sequence s_low_word_out;
    (st_reg.st == dbg_cmd_pkg::ST_RES_LO) && fv
    ##1 (st_reg.rsp.data == $past(st_reg.res_lo)) && !st_reg.rsp.s;
  endsequence

  property p_busy_not_ready;
    st_reg.mem.req |-> st_reg.rsp == dbg_cmd_pkg::RSP_NOT_READY;
  endproperty
  a_busy_not_ready: assert property (p_busy_not_ready)
    else $error("answer not not-ready during memory access");

  property p_aligned;
    st_reg.mem.req |-> (st_reg.mem.size != dbg_cmd_pkg::SZ_WORD ||
      !st_reg.mem.addr[0]) && (st_reg.mem.size != dbg_cmd_pkg::SZ_LONG ||
      st_reg.mem.addr[1:0] == 2'h0);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("memory address not aligned to size");

  property p_illegal;
    idle_frame && illegal |=> st_reg.rsp == dbg_cmd_pkg::RSP_ILLEGAL &&
      st_reg.st == dbg_cmd_pkg::ST_IDLE && !st_reg.chain;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal command not answered illegal");

  property p_dump_needs_chain;
    idle_frame && is_dmp && !st_reg.chain |=>
      st_reg.rsp == dbg_cmd_pkg::RSP_ILLEGAL && !st_reg.mem.req;
  endproperty
  a_dump_needs_chain: assert property (p_dump_needs_chain)
    else $error("dump accepted without preceding read");

  property p_cmd_not_ready;
    idle_frame && !illegal && !is_nop |=>
      st_reg.rsp == dbg_cmd_pkg::RSP_NOT_READY;
  endproperty
  a_cmd_not_ready: assert property (p_cmd_not_ready)
    else $error("command transfer not followed by not-ready");

  property p_bus_error;
    st_reg.mem.req && mem_err_i |=>
      st_reg.rsp == dbg_cmd_pkg::RSP_BUSERR && !st_reg.mem.req;
  endproperty
  a_bus_error: assert property (p_bus_error)
    else $error("bus error not reported as 0x0001 with status");

  property p_read_starts;
    fv && st_reg.st == dbg_cmd_pkg::ST_ADDR_LO &&
      st_reg.cmd[dbg_cmd_pkg::DIR_BIT] |=>
      st_reg.mem.req && !st_reg.mem.we ##1 st_reg.mem.req;
  endproperty
  a_read_starts: assert property (p_read_starts)
    else $error("read not started after low address word");

  property p_step;
    st_reg.mem.req && mem_ack_i && !mem_err_i && !st_reg.mem.we |=>
      st_reg.tmp_addr == $past(st_reg.mem.addr) +
      step($past(st_reg.mem.size)) && st_reg.chain;
  endproperty
  a_step: assert property (p_step)
    else $error("temporary address not advanced by size");

  property p_reg_halt;
    fv && st_reg.st == dbg_cmd_pkg::ST_WAIT && !cpu_halted_i &&
      st_reg.cmd[15:4] == dbg_cmd_pkg::CMD_RREG |=>
      st_reg.rsp == dbg_cmd_pkg::RSP_BUSERR && !st_reg.rg.req;
  endproperty
  a_reg_halt: assert property (p_reg_halt)
    else $error("register read while running not refused");

  property p_long_result;
    s_long_read_done |=> st_reg.rsp.data == $past(mem_rdata_i[31:16]) &&
      st_reg.res_lo == $past(mem_rdata_i[15:0]) &&
      st_reg.st == dbg_cmd_pkg::ST_RES_LO;
  endproperty
  a_long_result: assert property (p_long_result)
    else $error("longword result not returned high word first");

  property p_low_word;
    (st_reg.st == dbg_cmd_pkg::ST_RES_LO) && fv |-> s_low_word_out;
  endproperty
  a_low_word: assert property (p_low_word)
    else $error("low result word not queued for next command");

  property p_reg_write_done;
    st_reg.st == dbg_cmd_pkg::ST_REG && reg_ack_i && st_reg.rg.we |=>
      st_reg.rsp == dbg_cmd_pkg::RSP_DONE ##1
      st_reg.st == dbg_cmd_pkg::ST_IDLE || fv;
  endproperty
  a_reg_write_done: assert property (p_reg_write_done)
    else $error("register write completion not 0xffff");
endmodule

// ===== verif/debug_host.sv
// debug host model: serial frames out, responses in
`timescale 1ns/1ps
module debug_host (
  output logic dsclk_o,
  output logic dsi_o,
  input wire logic dso_i
);
  initial begin
    dsclk_o = 1'b0;
    dsi_o = 1'b0;
  end
  // one exchange, msb first; link clock stands low between frames
  task automatic xfer(input logic [15:0] w, output logic [16:0] r);
    for (int i = 16; i >= 0; i--) begin
      dsi_o = (i == 16) ? 1'b0 : w[i];
      #24;
      r[i] = dso_i;
      dsclk_o = 1'b1;
      #24;
      dsclk_o = 1'b0;
    end
    dsi_o = ~dsi_o; // released line must not keep the last bit
    #200;
  endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench of the debug serial command engine
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dsclk, dsi;
  logic dso_o, cpu_halted_i, mem_ack_i, mem_err_i, reg_ack_i, err_mode;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, mem_rdata_i, reg_rdata_i, reg_wdata;
  logic [31:0] q, a, d, seed;
  logic [8:0] lat, mcnt;
  dbg_cmd_pkg::mem_req_s mem_o, last_mem;
  dbg_cmd_pkg::reg_req_s reg_o;
  int miscompares, samples_checked;
  localparam logic [16:0] NR = dbg_cmd_pkg::RSP_NOT_READY;
  debug_serial_command_engine u_debug_serial_command_engine (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dsclk_i(dsclk), .dsi_i(dsi), .dso_o(dso_o), .cpu_halted_i(cpu_halted_i),
    .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
    .mem_err_i(mem_err_i), .reg_o(reg_o), .reg_rdata_i(reg_rdata_i),
    .reg_ack_i(reg_ack_i));
  debug_host u_debug_host (.dsclk_o(dsclk), .dsi_o(dsi), .dso_i(dso_o));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] md(input logic [31:0] x);
    return {~x[15:0], x[15:0]};
  endfunction
  task automatic cw(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic sx(input logic [15:0] w, input logic [16:0] e,
                    input logic [16:0] m = 17'h1ffff);
    logic [16:0] r;
    // frames start on the falling edge, so dso is never read as it moves
    @(negedge clk_i);
    u_debug_host.xfer(w, r);
    samples_checked++;
    if ((r & m) !== (e & m)) begin
      miscompares++;
      $display("[FAIL] %0t sent %h got %h exp %h", $time, w, r, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, output logic [31:0] o);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= 32'h1d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    o = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, far memory and register file
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    seed <= lf(seed);
    mem_ack_i <= 1'b0;
    mem_err_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i; // no stale data outside an answer
    reg_ack_i <= reg_o.req && !reg_ack_i && seed[0];
    // distinct halves expose word order; the low bits expose the select
    reg_rdata_i <= reg_wdata ^ {28'h0, reg_o.sel};
    if (reg_o.req && reg_o.we)
      reg_wdata <= reg_o.wdata;
    if (!mem_o.req)
      mcnt <= lat;
    else if (mcnt != 9'h0)
      mcnt <= mcnt - 9'h1;
    else if (!mem_ack_i && !mem_err_i) begin
      mem_ack_i <= !err_mode;
      mem_err_i <= err_mode;
      mem_rdata_i <= md(mem_o.addr);
      last_mem <= mem_o;
    end
  end
  initial begin
    #300000;
    miscompares++;
    close_out;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, mem_ack_i, mem_err_i, reg_ack_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, mem_rdata_i, reg_rdata_i} = '0;
    {cpu_halted_i, err_mode, lat, rst_i} = {1'b1, 1'b0, 9'h3, 1'b1};
    {seed, miscompares, samples_checked} = {32'h0ccfcc63, 64'h0};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    sx(16'h1d00, 17'h0ffff);
    sx(16'h0000, 17'h1ffff);
    sx(16'hfc00, 17'h0ffff);
    sx(16'h0000, 17'h1ffff);
    $display("test illegal done");
    wb(1'b1, 8'h00, q);
    wb(1'b0, 8'h00, q);
    cw(q, 32'h1d);
    wb(1'b0, 8'h08, q);
    cw(q, 32'h0);
    wb(1'b0, 8'h04, q);
    cw(q, 32'h801);
    a = seed;
    d = md({a[31:2], 2'b00});
    lat <= 9'd300; // a long access so the next frame lands inside it
    sx(16'h1980, 17'h0ffff);
    sx(a[31:16], NR);
    sx(a[15:0], NR);
    sx(16'h0000, NR);
    wait (mem_o.req === 1'b0);
    repeat (4) @(posedge clk_i);
    lat <= {6'h0, seed[2:0]};
    sx(16'h0000, {1'b0, d[31:16]});
    sx(16'h0000, {1'b0, d[15:0]});
    cw(last_mem.addr, {a[31:2], 2'b00});
    cw({27'h0, last_mem.tm, last_mem.tt}, 32'h1d);
    $display("test read done");
    a = {seed[31:2], 2'b00};
    sx(16'h1900, 17'h0ffff);
    sx(a[31:16], NR);
    sx(a[15:0], NR);
    sx(16'h1d00, {9'h0, a[7:0]}, 17'h100ff);
    sx(16'h0000, NR);
    sx(16'h1d40, {9'h0, a[7:0] + 8'h1}, 17'h100ff);
    sx(16'h0000, NR);
    sx(16'h1d80, {1'b0, a[15:0] + 16'h2});
    sx(16'h0000, NR);
    sx(16'h0000, {1'b0, ~(a[15:0] + 16'h4)});
    sx(16'h0000, {1'b0, a[15:0] + 16'h4});
    cw(last_mem.addr, a + 32'h4);
    $display("test dump done");
    // the dump chain is live here, so reset must visibly drop it
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    sx(16'h1d00, 17'h0ffff);
    sx(16'h0000, 17'h1ffff);
    $display("test reset done");
    err_mode <= 1'b1;
    sx(16'h1840, 17'h0ffff);
    sx(a[31:16], NR);
    sx(a[15:0], NR);
    sx(16'hbeef, NR);
    sx(16'h1d00, 17'h10001);
    sx(16'h0000, 17'h1ffff);
    cw({last_mem.we, last_mem.wdata[15:0]}, 32'h1beef);
    err_mode <= 1'b0;
    d = seed;
    sx(16'h1880, 17'h0ffff);
    sx(a[31:16], NR);
    sx(a[15:0], NR);
    sx(d[31:16], NR);
    sx(d[15:0], NR);
    sx(16'h0000, 17'h0ffff);
    cw(last_mem.wdata, d);
    cw(last_mem.addr, a);
    $display("test write done");
    d = seed;
    sx(16'h2083, 17'h0ffff);
    sx(d[31:16], NR);
    sx(d[15:0], NR);
    sx(16'h2183, 17'h0ffff);
    cw(reg_wdata, d);
    sx(16'h0000, NR);
    sx(16'h0000, {1'b0, d[31:16]});
    sx(16'h0000, {1'b0, d[15:0] ^ 16'h3});
    cpu_halted_i <= 1'b0;
    sx(16'h218b, 17'h0ffff);
    sx(16'h0000, NR);
    sx(16'h0000, 17'h10001);
    sx(16'h208b, 17'h0ffff);
    sx(d[31:16], NR);
    sx(d[15:0], NR);
    sx(16'h0000, 17'h10001);
    $display("test register done");
    close_out;
  end
endmodule
